// *** logic/pmu_pkg.sv ***
/*
 * pmu_pkg: register indices, field positions and reset values of the
 * power management control bank.
 * Assumes a 32-bit classic Wishbone bus; byte address = 4 * index.
 */
package pmu_pkg;
	// register indices (byte address is four times the index)
	localparam logic [5:0] PMU_IDX_SYS  = 6'h00;
	localparam logic [5:0] PMU_IDX_HIB  = 6'h01;
	localparam logic [5:0] PMU_IDX_STAT = 6'h02;
	localparam logic [5:0] PMU_IDX_MASK = 6'h03;
	localparam logic [5:0] PMU_IDX_V1   = 6'h20;
	localparam logic [5:0] PMU_IDX_V2   = 6'h21;
	localparam logic [5:0] PMU_IDX_CTL  = 6'h22;
	// system register fields
	localparam int PMU_SYS_TRST  = 7;
	localparam int PMU_SYS_MODE  = 6;
	localparam int PMU_SYS_UNMSK = 5;
	localparam int PMU_SYS_LOW   = 4;
	localparam logic [7:0] PMU_SYS_RW = 8'hef;
	// hibernate register fields
	localparam int PMU_HIB_FRC = 6;
	localparam int PMU_HIB_RDY = 1;
	localparam logic [7:0] PMU_HIB_RW  = 8'h4f;
	localparam logic [7:0] PMU_HIB_SCR = 8'h0d;
	// converter control fields
	localparam int PMU_CTL_ON    = 7;
	localparam int PMU_CTL_PHASE = 6;
	localparam int PMU_CTL_MODE  = 5;
	localparam int PMU_CTL_DLY   = 2;
	localparam int PMU_CTL_FMSK  = 1;
	localparam int PMU_CTL_OK    = 0;
	localparam logic [7:0] PMU_CTL_RW = 8'hfe;
	// event bits of status and mask
	localparam int PMU_EV_LEV = 0;
	localparam int PMU_EV_FLT = 1;
	// values after reset
	localparam logic [7:0] PMU_SYS_RST = 8'hc7;
	localparam logic [7:0] PMU_HIB_RST = 8'h00;
	localparam logic [5:0] PMU_V1_RST  = 6'h14;
	localparam logic [5:0] PMU_V2_RST  = 6'h10;
	localparam logic [7:0] PMU_CTL_RST = 8'h00;
	localparam logic [1:0] PMU_EV_RST  = 2'h0;
	// register state of the bank
	typedef struct packed {
		logic [7:0] sys;
		logic [7:0] hib;
		logic [5:0] v1;
		logic [5:0] v2;
		logic [7:0] ctl;
		logic [1:0] stat;
		logic [1:0] mask;
		logic       ack;
		logic [7:0] rdata;
		logic [5:0] vout;
		logic       shut;
		logic [1:0] sup_s;
		logic       sup_d;
		logic [1:0] pg_s;
		logic [1:0] flt_s;
		logic       flt_d;
		logic [1:0] voltage_bank_select_pin_s;
		logic [1:0] hib_s;
		logic [1:0] uvlo_s;
		logic [1:0] off_s;
		logic       off_d;
	} pmu_state_s;
endpackage : pmu_pkg

// *** logic/pmu_regs.sv ***
/*
 * pmu_regs: control and status bank of the system monitor, hibernate
 * support and first step-down converter, as a classic Wishbone slave.
 * Assumes analog status inputs arrive asynchronously and that the
 * undervoltage and shutdown indications are held for several cycles.
 */
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ns
module pmu_regs
	import pmu_pkg::*;
#(
	parameter int ADR_W = 8
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// wishbone slave
	input  wire logic             cyc_i,
	input  wire logic             stb_i,
	input  wire logic             we_i,
	input  wire logic [ADR_W-1:0] adr_i,
	input  wire logic [3:0]       sel_i,
	input  wire logic [31:0]      dat_i,
	output      logic [31:0]      dat_o,
	output      logic             ack_o,
	// analog and system status (asynchronous)
	input  wire logic             supply_below_i,
	input  wire logic             buck_one_pgood_i,
	input  wire logic             buck_one_fault_i,
	input  wire logic             voltage_bank_select_pin_i,
	input  wire logic             hibernate_i,
	input  wire logic             uvlo_i,
	input  wire logic             system_off_i,
	// regulator and monitor controls
	output      logic [3:0]       supply_threshold_code_o,
	output      logic             reset_timer_select_o,
	output      logic [5:0]       buck_one_vcode_o,
	output      logic             buck_one_enable_o,
	output      logic             buck_one_phase_o,
	output      logic             buck_one_pwm_only_o,
	output      logic [2:0]       buck_one_delay_o,
	output      logic             shutdown_req_o,
	output      logic             irq_o
);
	// reset image of the whole state
	localparam pmu_state_s RST_S = '{
		sys: PMU_SYS_RST, hib: PMU_HIB_RST, v1: PMU_V1_RST,
		v2: PMU_V2_RST, ctl: PMU_CTL_RST, stat: PMU_EV_RST,
		mask: PMU_EV_RST, vout: PMU_V1_RST, default: '0};

	pmu_state_s q_reg;
	pmu_state_s q_next;
	logic [5:0] idx;
	logic       acc;
	logic       wr;
	logic       low_rise;
	logic       flt_rise;
	logic       off_evt;
	logic [1:0] ev;
	logic [1:0] gate;

	// index decode: registers are 8 bits in one word each
	assign idx = adr_i[7:2];
	assign acc = cyc_i && stb_i && !q_reg.ack;
	assign wr  = acc && we_i && sel_i[0];

	generate
		if (ADR_W < 8) begin : g_bad_adr
			$error("pmu_regs: ADR_W must be at least 8");
		end
	endgenerate

	// next-state logic of the whole bank
	always_comb begin
		q_next = q_reg;
		// two-flop synchronisers; only stage two is read downstream
		q_next.sup_s  = {q_reg.sup_s[0], supply_below_i};
		q_next.pg_s   = {q_reg.pg_s[0], buck_one_pgood_i};
		q_next.flt_s  = {q_reg.flt_s[0], buck_one_fault_i};
		q_next.voltage_bank_select_pin_s = {q_reg.voltage_bank_select_pin_s[0], voltage_bank_select_pin_i};
		q_next.hib_s  = {q_reg.hib_s[0], hibernate_i};
		q_next.uvlo_s = {q_reg.uvlo_s[0], uvlo_i};
		q_next.off_s  = {q_reg.off_s[0], system_off_i};
		q_next.sup_d  = q_reg.sup_s[1];
		q_next.flt_d  = q_reg.flt_s[1];
		q_next.off_d  = q_reg.off_s[1];

		low_rise = q_reg.sup_s[1] && !q_reg.sup_d;
		flt_rise = q_reg.flt_s[1] && !q_reg.flt_d;
		// falling below threshold: interrupt or shutdown
		ev[PMU_EV_LEV] = low_rise && q_reg.sys[PMU_SYS_MODE];
		ev[PMU_EV_FLT] = flt_rise;
		q_next.shut = low_rise && !q_reg.sys[PMU_SYS_MODE];
		off_evt = q_next.shut || (q_reg.off_s[1] && !q_reg.off_d);

		// single registered ack, dropped the cycle after
		q_next.ack = acc;

		// writes keep stored bits only; status and reserved stay out
		if (wr) begin
			unique case (idx)
				PMU_IDX_SYS:
					q_next.sys = dat_i[7:0] & PMU_SYS_RW;
				PMU_IDX_HIB:
					q_next.hib = dat_i[7:0] & PMU_HIB_RW;
				PMU_IDX_MASK:
					q_next.mask = dat_i[1:0];
				PMU_IDX_V1:
					q_next.v1 = dat_i[5:0];
				PMU_IDX_V2:
					q_next.v2 = dat_i[5:0];
				PMU_IDX_CTL:
					q_next.ctl = dat_i[7:0] & PMU_CTL_RW;
				default: ;
			endcase
		end

		// write-one-to-clear; a new event in the same cycle wins
		q_next.stat = q_reg.stat;
		if (wr && idx == PMU_IDX_STAT) begin
			q_next.stat = q_reg.stat & ~dat_i[1:0];
		end
		q_next.stat = q_next.stat | ev;

		// shutdown wipes the scratchpad; ready and force-on survive
		if (off_evt) begin
			q_next.hib = q_next.hib & ~PMU_HIB_SCR;
		end

		// read data captured with the ack
		q_next.rdata = '0;
		if (acc && !we_i) begin
			unique case (idx)
				PMU_IDX_SYS: begin
					q_next.rdata = q_reg.sys;
					q_next.rdata[PMU_SYS_LOW] = q_reg.sup_s[1];
				end
				PMU_IDX_HIB:  q_next.rdata = q_reg.hib;
				PMU_IDX_STAT: q_next.rdata = {6'h00, q_reg.stat};
				PMU_IDX_MASK: q_next.rdata = {6'h00, q_reg.mask};
				PMU_IDX_V1:   q_next.rdata = {2'h0, q_reg.v1};
				PMU_IDX_V2:   q_next.rdata = {2'h0, q_reg.v2};
				PMU_IDX_CTL: begin
					q_next.rdata = q_reg.ctl;
					q_next.rdata[PMU_CTL_OK] = q_reg.pg_s[1];
				end
				default: q_next.rdata = '0;
			endcase
		end

		// voltage bank select follows the pin
		q_next.vout = q_reg.voltage_bank_select_pin_s[1] ? q_reg.v2 : q_reg.v1;

		// undervoltage reloads every register default; the bus and
		// synchronisers keep running so a read still answers
		if (q_reg.uvlo_s[1]) begin
			q_next.sys  = PMU_SYS_RST;
			q_next.hib  = PMU_HIB_RST;
			q_next.v1   = PMU_V1_RST;
			q_next.v2   = PMU_V2_RST;
			q_next.ctl  = PMU_CTL_RST;
			q_next.stat = PMU_EV_RST;
			q_next.mask = PMU_EV_RST;
		end
	end

	// the one state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_reg <= RST_S;
		end else begin
			q_reg <= q_next;
		end
	end

	// interrupt gate: mask register and the per-source unmask bits
	assign gate[PMU_EV_LEV] = q_reg.sys[PMU_SYS_UNMSK];
	assign gate[PMU_EV_FLT] = q_reg.ctl[PMU_CTL_FMSK];
	assign irq_o = |(q_reg.stat & q_reg.mask & gate);

	// outputs to the bus and the analog side
	assign dat_o  = {24'h000000, q_reg.rdata};
	assign ack_o  = q_reg.ack;
	assign supply_threshold_code_o = q_reg.sys[3:0];
	assign reset_timer_select_o = q_reg.sys[PMU_SYS_TRST];
	assign buck_one_vcode_o = q_reg.vout;
	// force-on holds the converter up only while hibernating
	assign buck_one_enable_o = q_reg.ctl[PMU_CTL_ON] ||
		(q_reg.hib[PMU_HIB_FRC] && q_reg.hib_s[1]);
	assign buck_one_phase_o = q_reg.ctl[PMU_CTL_PHASE];
	assign buck_one_pwm_only_o = q_reg.ctl[PMU_CTL_MODE];
	assign buck_one_delay_o = q_reg.ctl[PMU_CTL_DLY +: 3];
	assign shutdown_req_o = q_reg.shut;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_mode_irq;
		q_reg.sup_s[1] && !q_reg.sup_d && q_reg.sys[PMU_SYS_MODE]
			&& !q_reg.uvlo_s[1] |=> q_reg.stat[PMU_EV_LEV] && !shutdown_req_o;
	endproperty
	a_mode_irq: assert property (p_mode_irq)
		else $error("level event lost in interrupt mode");

	property p_mode_shut;
		q_reg.sup_s[1] && !q_reg.sup_d && !q_reg.sys[PMU_SYS_MODE]
			|=> shutdown_req_o ##1 !shutdown_req_o;
	endproperty
	a_mode_shut: assert property (p_mode_shut)
		else $error("no single shutdown pulse in shutdown mode");

	property p_lev_mask;
		irq_o |-> (q_reg.stat & q_reg.mask & gate) != 2'h0
			&& !(q_reg.stat == 2'h1 && !q_reg.sys[PMU_SYS_UNMSK]);
	endproperty
	a_lev_mask: assert property (p_lev_mask)
		else $error("interrupt raised while masked");

	property p_low_read;
		acc && !we_i && idx == PMU_IDX_SYS
			|=> ack_o && dat_o[PMU_SYS_LOW] == $past(q_reg.sup_s[1]);
	endproperty
	a_low_read: assert property (p_low_read)
		else $error("supply low flag read wrong");

	property p_voltage_bank_select_pin;
		q_reg.voltage_bank_select_pin_s[1] |=> buck_one_vcode_o == $past(q_reg.v2);
	endproperty
	a_voltage_bank_select_pin: assert property (p_voltage_bank_select_pin)
		else $error("secondary code not selected");

	property p_scratch;
		q_next.shut && !q_reg.uvlo_s[1] |=> (q_reg.hib & PMU_HIB_SCR) == 8'h00;
	endproperty
	a_scratch: assert property (p_scratch)
		else $error("scratch bits survived shutdown");

	property p_uvlo;
		q_reg.uvlo_s[1] |=> q_reg.sys == PMU_SYS_RST
			&& q_reg.ctl == PMU_CTL_RST && !buck_one_phase_o;
	endproperty
	a_uvlo: assert property (p_uvlo)
		else $error("defaults not restored on undervoltage");

	property p_rsvd;
		ack_o |-> dat_o[31:8] == 24'h000000
			&& ($past(idx) != PMU_IDX_V1 || dat_o[7:6] == 2'h0);
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved bits read nonzero");

	property p_ack_once;
		ack_o |=> !ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("ack held longer than one cycle");

	// a system write lands in the threshold code the next cycle
	property p_thresh;
		wr && idx == PMU_IDX_SYS && !q_reg.uvlo_s[1]
			|=> supply_threshold_code_o == $past(dat_i[3:0]);
	endproperty
	a_thresh: assert property (p_thresh)
		else $error("threshold code not taken from write");

	// the reset timer select follows the written top bit
	property p_trst;
		wr && idx == PMU_IDX_SYS && !q_reg.uvlo_s[1]
			|=> reset_timer_select_o == $past(dat_i[PMU_SYS_TRST]);
	endproperty
	a_trst: assert property (p_trst)
		else $error("reset timer select not taken from write");

	// the low flag is never stored, so a write cannot fake it
	property p_low_keep;
		wr && idx == PMU_IDX_SYS |=> !q_reg.sys[PMU_SYS_LOW];
	endproperty
	a_low_keep: assert property (p_low_keep)
		else $error("write reached the supply low flag");

	// select low picks the primary code one cycle later
	property p_v1_sel;
		!q_reg.voltage_bank_select_pin_s[1] |=> buck_one_vcode_o == $past(q_reg.v1);
	endproperty
	a_v1_sel: assert property (p_v1_sel)
		else $error("primary code not selected");

	// without force-on the enable is the written bit alone
	property p_enable;
		wr && idx == PMU_IDX_CTL && !q_reg.hib[PMU_HIB_FRC]
			&& !q_reg.uvlo_s[1]
			|=> buck_one_enable_o == $past(dat_i[PMU_CTL_ON]);
	endproperty
	a_enable: assert property (p_enable)
		else $error("converter enable not taken from write");

	// force-on during hibernate keeps the converter running
	property p_force;
		q_reg.hib[PMU_HIB_FRC] && q_reg.hib_s[1] |-> buck_one_enable_o;
	endproperty
	a_force: assert property (p_force)
		else $error("converter dropped while forced on");

	// phase control follows the written bit
	property p_phase;
		wr && idx == PMU_IDX_CTL && !q_reg.uvlo_s[1]
			|=> buck_one_phase_o == $past(dat_i[PMU_CTL_PHASE]);
	endproperty
	a_phase: assert property (p_phase)
		else $error("phase control not taken from write");

	// fixed PWM select follows the written bit
	property p_pwm;
		wr && idx == PMU_IDX_CTL && !q_reg.uvlo_s[1]
			|=> buck_one_pwm_only_o == $past(dat_i[PMU_CTL_MODE]);
	endproperty
	a_pwm: assert property (p_pwm)
		else $error("mode select not taken from write");

	// turn-on delay follows the written field
	property p_delay;
		wr && idx == PMU_IDX_CTL && !q_reg.uvlo_s[1]
			|=> buck_one_delay_o == $past(dat_i[PMU_CTL_DLY +: 3]);
	endproperty
	a_delay: assert property (p_delay)
		else $error("turn-on delay not taken from write");

	// an unmasked, enabled fault must reach the interrupt line
	property p_flt_irq;
		q_reg.stat[PMU_EV_FLT] && q_reg.mask[PMU_EV_FLT]
			&& q_reg.ctl[PMU_CTL_FMSK] |-> irq_o;
	endproperty
	a_flt_irq: assert property (p_flt_irq)
		else $error("fault interrupt not raised");

	// with both unmask bits clear no event may interrupt
	property p_irq_off;
		!q_reg.sys[PMU_SYS_UNMSK] && !q_reg.ctl[PMU_CTL_FMSK] |-> !irq_o;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("interrupt passed with sources masked");

	// power good is read live from the synchroniser
	property p_pg_read;
		acc && !we_i && idx == PMU_IDX_CTL
			|=> ack_o && dat_o[PMU_CTL_OK] == $past(q_reg.pg_s[1]);
	endproperty
	a_pg_read: assert property (p_pg_read)
		else $error("power good bit read wrong");

	// reserved hibernate bits always read as zero
	property p_hib_rsvd;
		acc && !we_i && idx == PMU_IDX_HIB
			|=> !dat_o[7] && dat_o[5:4] == 2'h0;
	endproperty
	a_hib_rsvd: assert property (p_hib_rsvd)
		else $error("reserved hibernate bits read nonzero");
endmodule : pmu_regs

// *** tb/pmu_host.sv ***
/*
 * pmu_host: host processor model, a classic Wishbone master.
 * Assumes the slave answers with ack after some cycles; waits unbounded,
 * the bench watchdog cuts a hang short.
 */
`timescale 1ns/1ns
module pmu_host (
	// clock and slave answer
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	// master request
	output      logic        cyc_o,
	output      logic        stb_o,
	output      logic        we_o,
	output      logic [7:0]  adr_o,
	output      logic [3:0]  sel_o,
	output      logic [31:0] dat_o
);
	// bus idle at time zero
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o  = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'hf;
		dat_o = 32'h0;
	end

	// one classic cycle; ack and read data are taken at the rising
	// edge that samples ack high, and the request drops at that edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= w;
		adr_o <= a;
		dat_o <= d;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o  <= 1'b0;
	endtask : xfer
endmodule : pmu_host

// *** tb/tb.sv ***
/*
 * tb: self-checking bench of the power management register bank.
 * Assumes pmu_regs and the host model pmu_host; inputs move at posedge.
 */
`timescale 1ns/1ns
module tb;
	import pmu_pkg::*;
	// clock, reset and bus
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, q;
	// status inputs
	logic        supply_below_i, buck_one_pgood_i, buck_one_fault_i;
	logic        voltage_bank_select_pin_i, hibernate_i;
	logic        uvlo_i, system_off_i;
	// controls
	logic [3:0]  supply_threshold_code_o;
	logic [5:0]  buck_one_vcode_o;
	logic [2:0]  buck_one_delay_o;
	logic        reset_timer_select_o, buck_one_enable_o, buck_one_phase_o;
	logic        buck_one_pwm_only_o, shutdown_req_o, irq_o;
	int          n_mismatch = 0, n_tests = 0, n_sd = 0;

	pmu_regs uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .supply_below_i, .buck_one_pgood_i,
		.buck_one_fault_i, .voltage_bank_select_pin_i, .hibernate_i,
		.uvlo_i, .system_off_i, .supply_threshold_code_o,
		.reset_timer_select_o, .buck_one_vcode_o, .buck_one_enable_o,
		.buck_one_phase_o, .buck_one_pwm_only_o, .buck_one_delay_o,
		.shutdown_req_o, .irq_o);
	pmu_host host (.clk_i, .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc_i),
		.stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i),
		.dat_o(dat_i));

	// 50 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// shutdown pulses counted, since they stand a single cycle
	always @(posedge clk_i) if (shutdown_req_o === 1'b1) n_sd++;

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input string s, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		host.xfer(1'b1, {i, 2'b00}, {24'h0, d}, q);
	endtask : wr
	task automatic rd(input logic [5:0] i, input logic [7:0] e);
		host.xfer(1'b0, {i, 2'b00}, 32'h0, q);
		chk($sformatf("reg %h", i), {24'h0, e}, q);
	endtask : rd
	// outputs are looked at mid-cycle, away from the launching edge
	task automatic idle(input int n);
		repeat (n) @(negedge clk_i);
	endtask : idle
	function automatic logic [31:0] outs();
		return 32'({reset_timer_select_o, supply_threshold_code_o,
			buck_one_enable_o, buck_one_phase_o, buck_one_pwm_only_o,
			buck_one_delay_o});
	endfunction : outs

	// watchdog, far beyond the few hundred cycles of the sequence
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		end_of_test();
	end

	initial begin
		rst_i = 1'b1;
		{supply_below_i, buck_one_pgood_i, buck_one_fault_i} = 3'h0;
		{voltage_bank_select_pin_i, hibernate_i} = 2'h0;
		{uvlo_i, system_off_i} = 2'h0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		// defaults and an unmapped index
		rd(PMU_IDX_SYS, 8'hc7);
		rd(PMU_IDX_HIB, 8'h00);
		rd(PMU_IDX_V1, 8'h14);
		rd(PMU_IDX_V2, 8'h10);
		rd(PMU_IDX_CTL, 8'h00);
		rd(6'h10, 8'h00);
		chk("outs", 32'h5c0, outs());
		chk("vcode", 32'h14, 32'(buck_one_vcode_o));
		$display("test reset done");
		// all ones, then a mixed pattern on the controls
		wr(PMU_IDX_SYS, 8'hff);
		wr(PMU_IDX_HIB, 8'hff);
		wr(PMU_IDX_V1, 8'hff);
		wr(PMU_IDX_V2, 8'hff);
		wr(PMU_IDX_CTL, 8'hff);
		rd(PMU_IDX_SYS, 8'hef);
		rd(PMU_IDX_HIB, 8'h4f);
		rd(PMU_IDX_V1, 8'h3f);
		rd(PMU_IDX_V2, 8'h3f);
		rd(PMU_IDX_CTL, 8'hfe);
		chk("outs", 32'h7ff, outs());
		wr(PMU_IDX_SYS, 8'h85);
		wr(PMU_IDX_CTL, 8'ha8);
		idle(2);
		chk("outs", 32'h56a, outs());
		$display("test fields done");
		// voltage bank select
		wr(PMU_IDX_V1, 8'h2a);
		wr(PMU_IDX_V2, 8'h15);
		idle(4);
		chk("vcode", 32'h2a, 32'(buck_one_vcode_o));
		@(posedge clk_i) voltage_bank_select_pin_i <= 1'b1;
		idle(5);
		chk("vcode", 32'h15, 32'(buck_one_vcode_o));
		$display("test voltage_bank_select_pin done");
		// low supply with interrupt response
		wr(PMU_IDX_SYS, 8'h60);
		wr(PMU_IDX_MASK, 8'h01);
		@(posedge clk_i) supply_below_i <= 1'b1;
		idle(6);
		chk("irq", 32'h1, 32'(irq_o));
		rd(PMU_IDX_SYS, 8'h70);
		wr(PMU_IDX_SYS, 8'h40);
		idle(2);
		chk("irq", 32'h0, 32'(irq_o));
		wr(PMU_IDX_SYS, 8'h60);
		wr(PMU_IDX_STAT, 8'h01);
		idle(2);
		chk("irq", 32'h0, 32'(irq_o));
		chk("sd", 32'h0, 32'(n_sd));
		@(posedge clk_i) supply_below_i <= 1'b0;
		idle(4);
		rd(PMU_IDX_SYS, 8'h60);
		$display("test level irq done");
		// low supply with shutdown response clears scratch
		wr(PMU_IDX_HIB, 8'h0f);
		wr(PMU_IDX_SYS, 8'h00);
		@(posedge clk_i) supply_below_i <= 1'b1;
		idle(8);
		chk("sd", 32'h1, 32'(n_sd));
		rd(PMU_IDX_HIB, 8'h02);
		rd(PMU_IDX_STAT, 8'h00);
		@(posedge clk_i) supply_below_i <= 1'b0;
		wr(PMU_IDX_HIB, 8'h0d);
		@(posedge clk_i) system_off_i <= 1'b1;
		idle(4);
		@(posedge clk_i) system_off_i <= 1'b0;
		rd(PMU_IDX_HIB, 8'h00);
		$display("test shutdown done");
		// fault interrupt and power good
		wr(PMU_IDX_CTL, 8'h02);
		wr(PMU_IDX_MASK, 8'h02);
		@(posedge clk_i) buck_one_fault_i <= 1'b1;
		idle(6);
		chk("irq", 32'h1, 32'(irq_o));
		rd(PMU_IDX_STAT, 8'h02);
		wr(PMU_IDX_CTL, 8'h00);
		idle(2);
		chk("irq", 32'h0, 32'(irq_o));
		@(posedge clk_i) buck_one_pgood_i <= 1'b1;
		idle(4);
		rd(PMU_IDX_CTL, 8'h01);
		$display("test fault done");
		// host prepares hibernate, then wakes and clears force-on
		wr(PMU_IDX_HIB, 8'h42);
		@(posedge clk_i) hibernate_i <= 1'b1;
		idle(4);
		chk("enable", 32'h1, 32'(buck_one_enable_o));
		@(posedge clk_i) hibernate_i <= 1'b0;
		idle(4);
		chk("enable", 32'h0, 32'(buck_one_enable_o));
		rd(PMU_IDX_HIB, 8'h42);
		wr(PMU_IDX_HIB, 8'h00);
		$display("test hibernate done");
		// undervoltage reloads defaults
		wr(PMU_IDX_V1, 8'h01);
		@(posedge clk_i) uvlo_i <= 1'b1;
		idle(4);
		@(posedge clk_i) uvlo_i <= 1'b0;
		idle(2);
		rd(PMU_IDX_V1, 8'h14);
		rd(PMU_IDX_SYS, 8'hc7);
		rd(PMU_IDX_MASK, 8'h00);
		$display("test undervoltage done");
		end_of_test();
	end
endmodule : tb
